// [rtl/serial_ctrl.sv]
// Purpose: Asynchronous serial transceiver with Wishbone register access.
// Assumes: Serial input synchronous to clk_i; one clock domain.
// Notes: Bit time is a count of base clocks from baud_divisor.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
// Function
// - Transmit buffer write starts transmission, resets FFH
// - Buffer to shift: first at once, continuous before done
// - Load and bit output on base clock tick
// - Power off: stop clock, reset, line high
// - Power off clears status, flags, receive buffer
// - Counter runs at second base clock after power
// - Transmit enable low resets transmit circuit
// - Receive enable low resets receive circuit
// - Character length seven or eight bits
// - Transmitter sends one or two stop bits
// - Receiver checks only first stop bit
// - Error routed to error or done interrupt
// - Receive enable on low line starts reception
// - Parity and framing errors; read clears flags
// - Overrun flagged, new byte discarded
// - Status registers clear on disable or power off
// - Buffer full and shift busy flags
module serial_ctrl (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [17:2] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Serial line
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	// Events
	output logic tx_done_irq_o,
	output logic rx_done_irq_o,
	output logic rx_error_irq_o
);
	import serial_ctrl_pkg::*;

	logic [7:0] operation_mode;
	logic [7:0] baud_divisor;
	logic [7:0] tx_buffer_reg;
	logic [7:0] tx_shift_reg;
	logic [7:0] rx_buffer_reg;
	logic [7:0] rx_shift_reg;
	logic tx_buffer_full_flag;
	logic tx_shift_busy_flag;
	logic parity_err_flag;
	logic framing_err_flag;
	logic overrun_err_flag;
	logic rx_full;
	tx_state_t tx_state;
	rx_state_t rx_state;
	logic [7:0] tx_cnt;
	logic [7:0] rx_cnt;
	logic [2:0] tx_bit;
	logic [2:0] rx_bit;
	logic [1:0] tx_stops;
	logic rx_par_bit;
	logic base_tick;
	logic run;
	logic bit_tick_en;

	logic unit_power_enable;
	logic tx_enable_bit;
	logic rx_enable_bit;
	parity_mode_t parity_select;
	logic char_length_sel;
	logic stop_len_sel;
	logic err_irq_route;
	logic tx_on;
	logic rx_on;
	logic rx_line;
	logic [2:0] last_bit;
	logic [7:0] char_mask;
	logic [7:0] bit_len;
	logic [7:0] half_len;
	logic req;
	logic wr;
	logic rd;
	logic wr_mode;
	logic wr_txb;
	logic rd_err;
	logic rd_rxb;
	logic tx_load;
	logic tx_frame_end;
	logic rx_tick;
	logic rx_done;
	logic rx_pe;
	logic rx_fe;
	logic [7:0] next_rx_data;

	assign unit_power_enable = operation_mode[`BIT_POWER];
	assign tx_enable_bit = operation_mode[`BIT_TX_EN];
	assign rx_enable_bit = operation_mode[`BIT_RX_EN];
	assign parity_select = parity_mode_t'(
		operation_mode[`BIT_PAR_HI:`BIT_PAR_LO]);
	assign char_length_sel = operation_mode[`BIT_CHAR_LEN];
	assign stop_len_sel = operation_mode[`BIT_STOP_LEN];
	assign err_irq_route = operation_mode[`BIT_ERR_ROUTE];
	assign tx_on = unit_power_enable && tx_enable_bit;
	assign rx_on = unit_power_enable && rx_enable_bit;
	// Input reads high while unpowered
	assign rx_line = unit_power_enable ? serial_in_pin_i : 1'b1;
	assign last_bit = char_length_sel ? 3'd7 : 3'd6;
	assign char_mask = char_length_sel ? 8'hff : 8'h7f;
	// Too short a divisor would leave no room for a mid-bit sample
	assign bit_len = (baud_divisor < `MIN_BAUD_DIVISOR) ?
		`MIN_BAUD_DIVISOR : baud_divisor;
	assign half_len = {1'b0, bit_len[7:1]};
	assign bit_tick_en = base_tick && run;

	base_clock_gen u_base (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.power_i(unit_power_enable),
		.base_tick_o(base_tick),
		.run_o(run)
	);

	// Wishbone: one wait state, ack registered
	assign req = ce_i && cyc_i && stb_i && !ack_o;
	assign wr = req && we_i && sel_i[0];
	assign rd = req && !we_i;
	assign wr_mode = wr && adr_i == `IDX_OPERATION_MODE;
	assign wr_txb = wr && adr_i == `IDX_TRANSMIT_BUFFER;
	assign rd_err = rd && adr_i == `IDX_RECEIVE_ERROR_STATUS;
	assign rd_rxb = rd && adr_i == `IDX_RX_BUFFER;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// Unmapped reads return zero, unmapped writes are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			unique case (adr_i)
				`IDX_OPERATION_MODE: dat_o <= {24'h0, operation_mode};
				`IDX_BAUD_DIVISOR: dat_o <= {24'h0, baud_divisor};
				`IDX_RX_BUFFER: dat_o <= {24'h0, rx_buffer_reg};
				`IDX_RECEIVE_ERROR_STATUS: dat_o <= {29'h0, parity_err_flag,
					framing_err_flag, overrun_err_flag};
				`IDX_TRANSMIT_BUFFER: dat_o <= {24'h0, tx_buffer_reg};
				`IDX_TRANSMIT_STATUS: dat_o <= {30'h0,
					tx_buffer_full_flag, tx_shift_busy_flag};
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			operation_mode <= `RST_OPERATION_MODE;
		end else if (wr_mode) begin
			operation_mode <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_divisor <= `RST_BAUD_DIVISOR;
		end else if (wr && adr_i == `IDX_BAUD_DIVISOR) begin
			baud_divisor <= dat_i[7:0];
		end
	end

	// Buffer keeps its value over disable; only reset sets FFH
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buffer_reg <= `RST_TRANSMIT_BUFFER;
		end else if (wr_txb) begin
			tx_buffer_reg <= dat_i[7:0];
		end
	end

	// Load at once when idle, or at frame end when continuing
	assign tx_frame_end = bit_tick_en && tx_state == TX_STOP &&
		tx_cnt == 8'h00 && tx_stops == 2'h0;
	assign tx_load = tx_buffer_full_flag && base_tick &&
		(tx_state == TX_IDLE || tx_frame_end);

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !tx_on)) begin
			tx_buffer_full_flag <= 1'b0;
		end else if (wr_txb) begin
			tx_buffer_full_flag <= 1'b1;
		end else if (tx_load) begin
			tx_buffer_full_flag <= 1'b0;
		end
	end

	// Transmit shifter; a power or enable drop resets it
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !tx_on)) begin
			tx_state <= TX_IDLE;
			tx_shift_reg <= 8'hff;
			tx_cnt <= 8'h00;
			tx_bit <= 3'd0;
			tx_stops <= 2'h0;
			tx_shift_busy_flag <= 1'b0;
			serial_out_pin_o <= 1'b1;
			tx_done_irq_o <= 1'b0;
		end else if (ce_i) begin
			tx_done_irq_o <= tx_frame_end;
			if (tx_load) begin
				tx_shift_reg <= tx_buffer_reg;
				tx_shift_busy_flag <= 1'b1;
				tx_state <= TX_START;
				tx_cnt <= 8'h00;
			end else if (tx_frame_end) begin
				tx_shift_busy_flag <= 1'b0;
				tx_state <= TX_IDLE;
			end else if (bit_tick_en) begin
				if (tx_cnt != 8'h00) begin
					tx_cnt <= tx_cnt - 8'h01;
				end else begin
					tx_cnt <= bit_len - 8'h01;
					unique case (tx_state)
						TX_IDLE: serial_out_pin_o <= 1'b1;
						TX_START: begin
							serial_out_pin_o <= 1'b0;
							tx_bit <= 3'd0;
							tx_state <= TX_DATA;
						end
						TX_DATA: begin
							serial_out_pin_o <= tx_shift_reg[tx_bit];
							if (tx_bit == last_bit) begin
								tx_state <= (parity_select == PAR_NONE) ?
									TX_STOP : TX_PAR;
								tx_stops <= stop_len_sel ? 2'h2 : 2'h1;
							end else begin
								tx_bit <= tx_bit + 3'd1;
							end
						end
						TX_PAR: begin
							unique case (parity_select)
								PAR_ZERO: serial_out_pin_o <= 1'b0;
								PAR_ODD: serial_out_pin_o <=
									~^(tx_shift_reg & char_mask);
								PAR_EVEN: serial_out_pin_o <=
									^(tx_shift_reg & char_mask);
								PAR_NONE: serial_out_pin_o <= 1'b1;
							endcase
							tx_state <= TX_STOP;
						end
						TX_STOP: begin
							// Each stop bit stands a full bit before frame end
							serial_out_pin_o <= 1'b1;
							tx_stops <= tx_stops - 2'h1;
						end
					endcase
				end
			end
		end
	end

	// Receiver; sampling mid-bit after a low line is seen
	assign rx_tick = bit_tick_en && rx_cnt == 8'h00;
	assign rx_done = rx_tick && rx_state == RX_STOP;
	assign rx_fe = !rx_line;
	assign rx_pe = (parity_select == PAR_ODD &&
		rx_par_bit != ~^(rx_shift_reg & char_mask)) ||
		(parity_select == PAR_EVEN &&
		rx_par_bit != ^(rx_shift_reg & char_mask));
	assign next_rx_data = rx_shift_reg & char_mask;

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !rx_on)) begin
			rx_state <= RX_IDLE;
			rx_shift_reg <= 8'hff;
			rx_cnt <= 8'h00;
			rx_bit <= 3'd0;
			rx_par_bit <= 1'b0;
		end else if (ce_i) begin
			if (rx_state == RX_IDLE) begin
				if (!rx_line && run) begin
					rx_state <= RX_START;
					rx_cnt <= half_len;
				end
			end else if (bit_tick_en && rx_cnt != 8'h00) begin
				rx_cnt <= rx_cnt - 8'h01;
			end else if (rx_tick) begin
				rx_cnt <= bit_len - 8'h01;
				unique case (rx_state)
					RX_START: begin
						rx_bit <= 3'd0;
						rx_state <= RX_DATA;
					end
					RX_DATA: begin
						rx_shift_reg[rx_bit] <= rx_line;
						if (rx_bit == last_bit) begin
							rx_state <= (parity_select == PAR_NONE) ?
								RX_STOP : RX_PAR;
						end else begin
							rx_bit <= rx_bit + 3'd1;
						end
					end
					RX_PAR: begin
						rx_par_bit <= rx_line;
						rx_state <= RX_STOP;
					end
					RX_STOP: rx_state <= RX_IDLE;
					RX_IDLE: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	// Receive buffer survives enable drop, not power drop
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !unit_power_enable)) begin
			rx_buffer_reg <= `RST_RX_BUFFER;
		end else if (rx_done && !rx_full) begin
			rx_buffer_reg <= next_rx_data;
		end
	end

	// Unread marker; a new byte beats a read in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !rx_on)) begin
			rx_full <= 1'b0;
		end else if (rx_done) begin
			rx_full <= 1'b1;
		end else if (rd_rxb) begin
			rx_full <= 1'b0;
		end
	end

	// Error flags: set wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !rx_on)) begin
			parity_err_flag <= 1'b0;
			framing_err_flag <= 1'b0;
			overrun_err_flag <= 1'b0;
		end else if (ce_i) begin
			if (rx_done) begin
				parity_err_flag <= rx_pe || (parity_err_flag && !rd_err);
				framing_err_flag <= rx_fe || (framing_err_flag && !rd_err);
				overrun_err_flag <= rx_full ||
					(overrun_err_flag && !rd_err);
			end else if (rd_err) begin
				parity_err_flag <= 1'b0;
				framing_err_flag <= 1'b0;
				overrun_err_flag <= 1'b0;
			end
		end
	end

	// Error goes to exactly one interrupt line
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !rx_on)) begin
			rx_done_irq_o <= 1'b0;
			rx_error_irq_o <= 1'b0;
		end else if (ce_i) begin
			if (rx_done && (rx_pe || rx_fe || rx_full)) begin
				rx_error_irq_o <= !err_irq_route;
				rx_done_irq_o <= err_irq_route;
			end else begin
				rx_error_irq_o <= 1'b0;
				rx_done_irq_o <= rx_done;
			end
		end
	end
endmodule : serial_ctrl

// [rtl/serial_ctrl_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: Wishbone byte address is four times the register index.
// Notes: Included by bare name.
`ifndef SERIAL_CTRL_DEFINES_SVH
`define SERIAL_CTRL_DEFINES_SVH

`define IDX_OPERATION_MODE 16'hff50
`define IDX_BAUD_DIVISOR 16'hff51
`define IDX_RX_BUFFER 16'hff52
`define IDX_RECEIVE_ERROR_STATUS 16'hff53
`define IDX_TRANSMIT_BUFFER 16'hff54
`define IDX_TRANSMIT_STATUS 16'hff55

`define RST_OPERATION_MODE 8'h01
`define RST_TRANSMIT_BUFFER 8'hff
`define RST_RX_BUFFER 8'hff
`define RST_BAUD_DIVISOR 8'hff
`define MIN_BAUD_DIVISOR 8'h08

`define BIT_POWER 7
`define BIT_TX_EN 6
`define BIT_RX_EN 5
`define BIT_PAR_HI 4
`define BIT_PAR_LO 3
`define BIT_CHAR_LEN 2
`define BIT_STOP_LEN 1
`define BIT_ERR_ROUTE 0

`define BIT_PARITY_ERR 2
`define BIT_FRAMING_ERR 1
`define BIT_OVERRUN_ERR 0
`define BIT_TX_BUF_FULL 1
`define BIT_TX_SHIFT_BUSY 0

`define BASE_CLOCK_NS 100
`define CLK_PERIOD_NS 10
`define BASE_DIV_CYCLES (`BASE_CLOCK_NS / `CLK_PERIOD_NS)
`define POWER_UP_BASE_CLOCKS 2

`endif

// [rtl/serial_ctrl_pkg.sv]
// Purpose: Types shared by the serial transceiver files.
// Assumes: Constants live in serial_ctrl_defines.svh.
// Notes: One-hot state codes.
package serial_ctrl_pkg;
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA = 5'b00100,
		TX_PAR = 5'b01000,
		TX_STOP = 5'b10000
	} tx_state_t;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_PAR = 5'b01000,
		RX_STOP = 5'b10000
	} rx_state_t;
	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ZERO = 2'b01,
		PAR_ODD = 2'b10,
		PAR_EVEN = 2'b11
	} parity_mode_t;
endpackage : serial_ctrl_pkg

// [rtl/base_clock_gen.sv]
// Purpose: Base clock tick and power-up gating of the bit counters.
// Assumes: Tick marks the falling edge of the base clock.
// Notes: Counters held while power is off.
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module base_clock_gen (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Control
	input wire logic power_i,
	// Ticks
	output logic base_tick_o,
	output logic run_o
);
	localparam int DIV = `BASE_DIV_CYCLES;
	logic [7:0] div_cnt;
	logic [1:0] up_cnt;

	// Divider stopped means base clock held low while unpowered
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !power_i)) begin
			div_cnt <= 8'h00;
		end else if (ce_i) begin
			if (div_cnt == 8'(DIV - 1)) begin
				div_cnt <= 8'h00;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end

	assign base_tick_o = ce_i && power_i && (div_cnt == 8'(DIV - 1));

	// Counter output enabled from the second base clock on
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !power_i)) begin
			up_cnt <= 2'h0;
		end else if (base_tick_o && up_cnt != 2'(`POWER_UP_BASE_CLOCKS)) begin
			up_cnt <= up_cnt + 2'h1;
		end
	end

	assign run_o = (up_cnt == 2'(`POWER_UP_BASE_CLOCKS));
endmodule : base_clock_gen

// [tb/serial_peer.sv]
// Purpose: Remote serial node that sends frames to the receiver.
// Assumes: Line idles high; one stop bit per frame.
// Notes: Parity and stop faults only when asked.
`timescale 1ns/100ps
module serial_peer #(
	parameter int BIT_NS = 800
) (
	// Serial line
	output logic line_o
);
	initial line_o = 1'b1;
	task automatic send(input logic [7:0] d, input int nb, input int par,
		input logic bad_par, input logic bad_stop);
		logic p;
		p = ^(nb == 7 ? {1'b0, d[6:0]} : d);
		// Offset keeps edges away from the sampling clock
		#3;
		line_o = 1'b0;
		#BIT_NS;
		for (int i = 0; i < nb; i++) begin
			line_o = d[i];
			#BIT_NS;
		end
		if (par != 0) begin
			line_o = (par == 1 ? 1'b0 : par == 2 ? ~p : p) ^ bad_par;
			#BIT_NS;
		end
		line_o = ~bad_stop;
		#BIT_NS;
		line_o = 1'b1;
		#BIT_NS;
	endtask : send
endmodule : serial_peer

// [tb/serial_ctrl_chk.sv]
// Purpose: Port assertions for the serial transceiver.
// Assumes: Mode writes are mirrored from the bus.
// Notes: Bound to serial_ctrl at the foot.
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module serial_ctrl_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [17:2] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Line and events
	input wire logic serial_in_pin_i,
	input wire logic serial_out_pin_o,
	input wire logic tx_done_irq_o,
	input wire logic rx_done_irq_o,
	input wire logic rx_error_irq_o
);
	logic pwr;
	logic txen;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Taken at the same edge as the design takes the write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr <= 1'b0;
			txen <= 1'b0;
		end else if (ce_i && cyc_i && stb_i && we_i && !ack_o && sel_i[0]
			&& adr_i == `IDX_OPERATION_MODE) begin
			pwr <= dat_i[`BIT_POWER];
			txen <= dat_i[`BIT_TX_EN];
		end
	end
	ack_pulse_a:
		assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_answer_a:
		assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	read_upper_a:
		assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper data set");
	irq_excl_a:
		assert property (!(rx_done_irq_o && rx_error_irq_o))
		else $error("both rx events");
	power_idle_a:
		assert property (!(pwr || $past(pwr) || $past(pwr, 2)) |->
			serial_out_pin_o && !tx_done_irq_o && !rx_done_irq_o)
		else $error("activity while off");
	txdone_en_a:
		assert property (tx_done_irq_o |-> txen || $past(txen))
		else $error("tx event while disabled");
	start_en_a:
		assert property ($fell(serial_out_pin_o) |-> $past(pwr && txen))
		else $error("start while disabled");
	bit_hold_a:
		assert property ($changed(serial_out_pin_o) |=>
			$stable(serial_out_pin_o) [*8]) else $error("short bit");
	stop_high_a:
		assert property (tx_done_irq_o |-> serial_out_pin_o)
		else $error("frame end not high");
	cover property (tx_done_irq_o);
	cover property (rx_done_irq_o);
	cover property (rx_error_irq_o);
endmodule : serial_ctrl_chk
bind serial_ctrl serial_ctrl_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
	.tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o),
	.rx_error_irq_o(rx_error_irq_o));

// [tb/testbench.sv]
// Purpose: Self-checking bench for the serial transceiver.
// Assumes: Divisor 8 gives 80 clocks per bit.
// Notes: Peer model drives the serial input.
`timescale 1ns/100ps
`include "serial_ctrl_defines.svh"
module testbench;
	localparam int BIT = 80;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [17:2] adr_i = 16'h0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o, serial_in_pin_i, serial_out_pin_o;
	logic tx_done_irq_o, rx_done_irq_o, rx_error_irq_o;
	int error_cnt = 0;
	int checks = 0;
	int cyc_n = 0;
	int n_done = 0;
	int n_err = 0;
	int nb;
	logic [4:0] m;
	logic [4:0] pm = 5'h01;
	logic [7:0] lastb = 8'hff;
	logic [7:0] q;
	logic [7:0] txq[$];
	serial_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
		.tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o),
		.rx_error_irq_o(rx_error_irq_o));
	serial_peer i_peer (.line_o(serial_in_pin_i));
	initial forever #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		n_done += int'(rx_done_irq_o === 1'b1);
		n_err += int'(rx_error_irq_o === 1'b1);
		if (cyc_n == 60000) begin
			error_cnt++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	task automatic chk_reg(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg
	task automatic chk_num(input string nm, input int lo, input int hi,
		input int g);
		checks++;
		if (g < lo || g > hi) begin
			error_cnt++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_num
	// Request held until ack is sampled high
	task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h0);
		chk_reg(nm, e, q);
	endtask : rc
	task automatic cap(input int nb, input int par, input int ns);
		logic [7:0] d;
		logic [7:0] e;
		int t;
		d = 8'h0;
		e = txq.pop_front();
		if (nb == 7) e[7] = 1'b0;
		while (serial_out_pin_o !== 1'b0) @(posedge clk_i);
		t = cyc_n;
		for (int i = 0; i < nb; i++) begin
			repeat (BIT) @(posedge clk_i);
			d[i] = serial_out_pin_o;
		end
		chk_reg("tx data", e, d);
		if (par != 0) begin
			repeat (BIT) @(posedge clk_i);
			chk_reg("tx parity", par == 1 ? 8'h0 : {7'h0, (par == 2) ^ (^e)},
				{7'h0, serial_out_pin_o});
		end
		while (tx_done_irq_o !== 1'b1) @(posedge clk_i);
		t = cyc_n - t - (1 + nb + ns + int'(par != 0)) * BIT;
		chk_num("frame length", -12, 12, t);
	endtask : cap
	task automatic rx_one(input int nb, input int par, input logic rt,
		input logic bp, input logic bs);
		logic [7:0] d;
		logic pe;
		int a;
		int b;
		d = 8'($urandom);
		a = n_done;
		b = n_err;
		pe = bp && par >= 2;
		i_peer.send(d, nb, par, bp, bs);
		rc(`IDX_RX_BUFFER, nb == 7 ? {1'b0, d[6:0]} : d, "rx buffer");
		rc(`IDX_RECEIVE_ERROR_STATUS, {5'h0, pe, bs, 1'b0}, "errors");
		chk_num("rx done", !(pe || bs) || rt, !(pe || bs) || rt, n_done - a);
		chk_num("rx error", (pe || bs) && !rt, (pe || bs) && !rt, n_err - b);
	endtask : rx_one
	initial begin
		void'($urandom(38));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(`IDX_OPERATION_MODE, `RST_OPERATION_MODE, "mode");
		rc(`IDX_TRANSMIT_BUFFER, 8'hff, "tx buffer");
		rc(`IDX_RECEIVE_ERROR_STATUS, 8'h00, "errors");
		rc(`IDX_TRANSMIT_STATUS, 8'h00, "tx status");
		rc(16'h0000, 8'h00, "unmapped");
		ce_i <= 1'b0;
		fork
			wb(1'b1, `IDX_BAUD_DIVISOR, 8'h08);
			begin
				repeat (20) @(posedge clk_i);
				chk_reg("frozen ack", 8'h00, {7'h0, ack_o});
				ce_i <= 1'b1;
			end
		join
		rc(`IDX_BAUD_DIVISOR, 8'h08, "divisor");
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			m = {i[1:0], i[2], i[0] ^ i[1], i[2]};
			nb = m[2] ? 8 : 7;
			wb(1'b1, `IDX_OPERATION_MODE, {3'b100, pm});
			wb(1'b1, `IDX_OPERATION_MODE, {3'b100, m});
			wb(1'b1, `IDX_OPERATION_MODE, {3'b111, m});
			pm = m;
			// Never refresh the buffer with the value it holds
			txq.push_back(lastb ^ 8'(1 + $urandom % 255));
			txq.push_back(txq[0] ^ 8'(1 + $urandom % 255));
			lastb = txq[1];
			wb(1'b1, `IDX_TRANSMIT_BUFFER, txq[0]);
			do wb(1'b0, `IDX_TRANSMIT_STATUS, 8'h0); while (q !== 8'h01);
			wb(1'b1, `IDX_TRANSMIT_BUFFER, txq[1]);
			rc(`IDX_TRANSMIT_STATUS, 8'h03, "tx status");
			cap(nb, int'(m[4:3]), m[1] + 1);
			cap(nb, int'(m[4:3]), m[1] + 1);
			rc(`IDX_TRANSMIT_STATUS, 8'h00, "tx status");
			rx_one(nb, int'(m[4:3]), m[0], 1'($urandom), 1'($urandom));
			$display("test mode %h done", m);
		end
		// Restart receiver: a bad stop may have begun a phantom frame
		wb(1'b1, `IDX_OPERATION_MODE, 8'h9d);
		wb(1'b1, `IDX_OPERATION_MODE, 8'hbd);
		i_peer.send(8'h5a, 8, 3, 1'b0, 1'b0);
		i_peer.send(8'ha5, 8, 3, 1'b0, 1'b0);
		rc(`IDX_RECEIVE_ERROR_STATUS, 8'h01, "errors");
		rc(`IDX_RECEIVE_ERROR_STATUS, 8'h00, "errors");
		rc(`IDX_RX_BUFFER, 8'h5a, "rx buffer");
		$display("test overrun done");
		i_peer.send(8'h33, 8, 3, 1'b0, 1'b1);
		wb(1'b1, `IDX_OPERATION_MODE, 8'h9d);
		wb(1'b1, `IDX_OPERATION_MODE, 8'h1d);
		rc(`IDX_RECEIVE_ERROR_STATUS, 8'h00, "errors");
		rc(`IDX_RX_BUFFER, `RST_RX_BUFFER, "rx buffer");
		rc(`IDX_TRANSMIT_STATUS, 8'h00, "tx status");
		$display("test power off done");
		summarize();
	end
endmodule : testbench
